//--- sim/tb_top.sv
// Self-checking bench for the velocity and length supervisor
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vls_pkg::*;
  localparam int Ms = 10;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, burstPulse, avgEnd, calActive, cmdActive;
  logic cmdPortTwo, trigIn, standbyIn, lengthValid, statusOpen, redLamp, busyLamp, dataOutEn;
  logic doubleGrid, critError, calAbort, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, velOut, lengthOut, q, v;
  vls_vel_s velIn;
  vls_len_s lenIn;
  int numErrors = 0;
  int compares = 0;
  int statusRises, c0, s, sum, prev, n;
  int ofsTab[3] = '{5, -7, 9999999};
  int burstTab[4] = '{2, 5, 3, 0};
  always #5 clk_sys = ~clk_sys;
  vls_supervisor #(.MsCycles(Ms)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .velIn(velIn), .lenIn(lenIn), .burstPulse(burstPulse), .avgEnd(avgEnd),
    .trigIn(trigIn), .standbyIn(standbyIn), .calActive(calActive), .cmdActive(cmdActive),
    .cmdPortTwo(cmdPortTwo), .velOut(velOut), .lengthOut(lengthOut),
    .lengthValid(lengthValid), .statusOpen(statusOpen), .redLamp(redLamp),
    .busyLamp(busyLamp), .dataOutEn(dataOutEn), .doubleGrid(doubleGrid),
    .critError(critError), .calAbort(calAbort)
  );
  vls_ctrl_model #(.GapCycles(12 * Ms)) u_ctrl (
    .clk_sys(clk_sys), .statusOpen(statusOpen), .trigIn(trigIn), .standbyIn(standbyIn),
    .statusRises(statusRises)
  );
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finishTest();
    $display("Compares %0d, errors %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finishTest
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic endt(input string name);
    $display("Test %s done, errors %0d", name, numErrors);
  endtask : endt
  function automatic logic [31:0] expLen(input int total, input int ofs);
    return 32'(total + ((ofs > 0) ? ofs : 0));
  endfunction : expLen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : apb
  task automatic pls(input int k, input logic [31:0] d);
    @(posedge clk_sys);
    case (k)
      0: velIn <= '{value: d, valid: 1'b1};
      1: lenIn <= '{step: d[15:0], valid: 1'b1};
      2: burstPulse <= 1'b1;
      default: avgEnd <= 1'b1;
    endcase
    @(posedge clk_sys);
    velIn.valid <= 1'b0;
    lenIn.valid <= 1'b0;
    burstPulse <= 1'b0;
    avgEnd <= 1'b0;
  endtask : pls
  // Bounded wait on length done (0) or calibration abort (1)
  task automatic waitHi(input int k);
    int m;
    m = 0;
    while (((k == 0) ? lengthValid : calAbort) !== 1'b1 && m < 40) begin
      @(posedge clk_sys);
      m++;
    end
  endtask : waitHi
  task automatic steps();
    sum = 0;
    repeat (2) begin
      s = $urandom_range(0, 400) - 200;
      sum += s;
      pls(1, 32'(s));
    end
  endtask : steps
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk_sys);
    numErrors++;
    finishTest();
  end
  initial begin
    {psel, penable, pwrite, burstPulse, avgEnd, calActive, cmdActive, cmdPortTwo} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    velIn = '0;
    lenIn = '0;
    void'($urandom(64));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, OFS_HOLD, 32'h0);
    chk(q, 32'h00000064);
    apb(1'b0, OFS_CNT, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, OFS_HOLD, 32'h00000005);
    apb(1'b0, OFS_HOLD, 32'h0);
    chk(q, 32'h0000000A);
    endt("reset");
    apb(1'b1, OFS_HOLD, 32'h0003000A); // Hold kept above lead
    v = $urandom;
    pls(0, v);
    repeat (4 * Ms) @(posedge clk_sys);
    chk({velOut[30:0], statusOpen}, {v[30:0], 1'b0});
    repeat (5 * Ms) @(posedge clk_sys);
    chk({velOut[30:0], statusOpen}, {v[30:0], 1'b1});
    repeat (4 * Ms) @(posedge clk_sys);
    chk(velOut, 32'h0);
    repeat (3) begin
      v = $urandom;
      pls(0, v);
      repeat ($urandom_range(2, 6 * Ms)) @(posedge clk_sys);
      chk({velOut[31:1], statusOpen}, {v[31:1], 1'b0});
    end
    endt("hold");
    c0 = $urandom_range(0, 60000);
    apb(1'b1, OFS_CNT, 32'(c0));
    apb(1'b0, OFS_CNT, 32'h0);
    chk(q, 32'(c0));
    for (int t = 0; t < 8; t++) begin
      u_ctrl.standby(t >= 4 && t < 6);
      apb(1'b1, OFS_CTRL, (t < 6) ? 32'(t) << CTRL_TRIG_LSB : 32'(t - 6) << CTRL_SELTRIG);
      repeat (3) @(posedge clk_sys);
      apb(1'b0, OFS_CNT, 32'h0);
      c0 = q;
      u_ctrl.part(t >= 6, 4);
      apb(1'b0, OFS_CNT, 32'h0);
      chk(q, 32'(c0 + ((t == 6) ? 0 : 1)));
    end
    endt("trigger");
    foreach (ofsTab[i]) begin
      apb(1'b1, OFS_LOFS, 32'(ofsTab[i]));
      pls(1, 32'h00000050);
      apb(1'b1, OFS_CTRL, 32'h00000100);
      steps();
      apb(1'b1, OFS_CTRL, 32'h00000200);
      waitHi(0);
      chk(lengthOut, expLen(sum, ofsTab[i]));
    end
    apb(1'b1, OFS_CTRL, 32'h00000120);
    waitHi(0);
    steps();
    prev = sum;
    apb(1'b1, OFS_CTRL, 32'h00000220);
    steps();
    apb(1'b1, OFS_CTRL, 32'h00000120);
    waitHi(0);
    chk(lengthOut, expLen(prev + sum, 9999999));
    endt("length");
    apb(1'b1, OFS_HOLD, 32'h0000000A);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_RATE, 32'h00000064);
    apb(1'b0, OFS_RATE, 32'h0);
    chk(q, 32'h00000063);
    apb(1'b1, OFS_RATE, 32'h00000003);
    pls(3, 32'h0);
    prev = 1;
    foreach (burstTab[i]) begin
      repeat (burstTab[i]) pls(2, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, statusOpen}, 32'(prev));
      pls(3, 32'h0);
      repeat (2) @(posedge clk_sys);
      prev = burstTab[i] < 3;
      chk({31'h0, statusOpen}, 32'(prev));
    end
    apb(1'b1, OFS_CTRL, 32'h00000008);
    chk({31'h0, statusOpen}, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    pls(3, 32'h0);
    apb(1'b1, OFS_RATE, 32'h0);
    chk({31'h0, statusOpen}, 32'h0);
    chk(32'(statusRises > 0), 32'h1);
    endt("rate");
    apb(1'b1, OFS_CTRL, 32'h00000104);
    repeat (3 * Ms) @(posedge clk_sys);
    apb(1'b0, OFS_STAT, 32'h0);
    chk({q[30:0], critError}, 32'h00000129);
    apb(1'b1, OFS_CTRL, 32'h00000204);
    apb(1'b1, OFS_STAT, 32'h00000030);
    calActive <= 1'b1;
    waitHi(1);
    chk({31'h0, calAbort}, 32'h1);
    calActive <= 1'b0;
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(q[ST_CALERR]), 32'h1);
    apb(1'b1, OFS_STAT, 32'h00000030);
    apb(1'b1, OFS_CTRL, 32'h0);
    calActive <= 1'b1;
    n = 0;
    repeat (3 * Ms) begin
      @(posedge clk_sys);
      n += (calAbort === 1'b1);
    end
    calActive <= 1'b0;
    chk(32'(n), 32'h0);
    endt("errors");
    cmdActive <= 1'b1;
    cmdPortTwo <= 1'b1;
    apb(1'b0, OFS_PORT, 32'h0);
    chk({q[29:0], busyLamp, dataOutEn}, 32'h0000000A);
    cmdPortTwo <= 1'b0;
    apb(1'b0, OFS_PORT, 32'h0);
    chk(q, 32'h1);
    cmdActive <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h00000001);
    chk({30'h0, doubleGrid, dataOutEn}, 32'h3);
    endt("port");
    finishTest();
  end
endmodule : tb_top
`default_nettype wire

//--- sim/vls_ctrl_model.sv
// Outside controller: drives trigger and standby lines, watches status
`default_nettype none
module vls_ctrl_model #(
  parameter int GapCycles = 120
) (
  input wire logic clk_sys,
  input wire logic statusOpen,
  output logic trigIn,
  output logic standbyIn,
  output int statusRises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic statusQ = 1'b0;
  initial begin
    trigIn = 1'b0;
    standbyIn = 1'b0;
    statusRises = 0;
  end
  // Counts rises of the status line, from warnings or low rate; the bench reads the count
  always @(posedge clk_sys) begin
    statusQ <= statusOpen;
    if (statusOpen === 1'b1 && statusQ !== 1'b1) begin
      statusRises <= statusRises + 1;
    end
  end
  task automatic standby(input logic lvl);
    @(posedge clk_sys);
    standbyIn <= lvl;
  endtask : standby
  // One part: line flips for width cycles, flips back, then a gap
  task automatic part(input logic onStandby, input int width);
    repeat (2) begin
      @(posedge clk_sys);
      if (onStandby) begin
        standbyIn <= ~standbyIn;
      end else begin
        trigIn <= ~trigIn;
      end
      repeat (width) @(posedge clk_sys);
    end
    repeat (GapCycles) @(posedge clk_sys); // Gap kept above the hold time
  endtask : part
endmodule : vls_ctrl_model
`default_nettype wire

//--- sim/vls_supervisor_assertions.sv
// Port-level checker for the velocity and length supervisor
`default_nettype none
module vls_sup_checker #(
  parameter int MsCycles = 10
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire vls_pkg::vls_vel_s velIn,
  input wire logic calActive,
  input wire logic cmdActive,
  input wire logic [31:0] velOut,
  input wire logic lengthValid,
  input wire logic statusOpen,
  input wire logic redLamp,
  input wire logic busyLamp,
  input wire logic dataOutEn,
  input wire logic doubleGrid,
  input wire logic critError,
  input wire logic calAbort
);
  timeunit 1ns;
  timeprecision 1ps;
  import vls_pkg::*;
  logic wrCtrl;
  logic clrCrit;
  assign wrCtrl = psel && penable && pwrite && paddr == OFS_CTRL;
  assign clrCrit = psel && penable && pwrite && paddr == OFS_STAT && pwdata[ST_CRIT];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_red; redLamp == statusOpen; endproperty
  a_red: assert property (p_red) else $error("Red lamp and status differ");
  property p_busy; cmdActive |-> busyLamp && !dataOutEn; endproperty
  a_busy: assert property (p_busy) else $error("Output not paused while busy");
  property p_idle; !cmdActive |-> !busyLamp && dataOutEn; endproperty
  a_idle: assert property (p_idle) else $error("Output paused while idle");
  property p_vload; velIn.valid |-> ##2 velOut == $past(velIn.value, 2); endproperty
  a_vload: assert property (p_vload) else $error("Valid velocity not shown");
  property p_vhold; !velIn.valid |-> ##2 velOut == $past(velOut) || velOut == 32'h0; endproperty
  a_vhold: assert property (p_vhold) else $error("Held velocity changed");
  property p_crit; critError && !clrCrit |=> critError; endproperty
  a_crit: assert property (p_crit) else $error("Critical error lost");
  property p_calp; calAbort |=> !calAbort; endproperty
  a_calp: assert property (p_calp) else $error("Abort longer than one cycle");
  property p_calc; calAbort |-> $past(calActive) || $past(calActive, 2); endproperty
  a_calc: assert property (p_calc) else $error("Abort outside calibration");
  property p_grid; !$stable(doubleGrid) |-> $past(wrCtrl); endproperty
  a_grid: assert property (p_grid) else $error("Grid mode moved without write");
  c_abort: cover property (calAbort);
  c_len: cover property (lengthValid);
  c_crit: cover property ($rose(critError));
  c_warn: cover property ($rose(statusOpen));
endmodule : vls_sup_checker

bind vls_supervisor vls_sup_checker #(.MsCycles(MsCycles)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .velIn(velIn), .calActive(calActive),
  .cmdActive(cmdActive), .velOut(velOut), .lengthValid(lengthValid),
  .statusOpen(statusOpen), .redLamp(redLamp), .busyLamp(busyLamp),
  .dataOutEn(dataOutEn), .doubleGrid(doubleGrid), .critError(critError),
  .calAbort(calAbort)
);
`default_nettype wire

//--- verilog/vls_pkg.sv
// Constants, register map and carrier types for the velocity and length supervisor
`default_nettype none
package vls_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HOLD = 8'h04;
  localparam logic [7:0] OFS_LOFS = 8'h08;
  localparam logic [7:0] OFS_RATE = 8'h0C;
  localparam logic [7:0] OFS_CNT = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_VEL = 8'h18;
  localparam logic [7:0] OFS_LEN = 8'h1C;
  localparam logic [7:0] OFS_PORT = 8'h20;
  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_MODE = 0;
  localparam int CTRL_SELTRIG = 1;
  localparam int CTRL_SIGERR = 2;
  localparam int CTRL_SURF = 3;
  localparam int CTRL_TRIG_LSB = 4;
  localparam int CTRL_START = 8;
  localparam int CTRL_STOP = 9;
  // Status register fields
  localparam int ST_STATUS = 0;
  localparam int ST_WARN = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_RATELOW = 3;
  localparam int ST_CRIT = 4;
  localparam int ST_CALERR = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_MEAS = 7;
  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [15:0] HOLD_RST = 16'h0064;
  localparam logic [15:0] LEAD_RST = 16'h0000;
  localparam logic [15:0] HOLD_MIN = 16'h000A;
  localparam logic [6:0] RATE_MAX = 7'h63;
  localparam logic [2:0] TRIG_RST = 3'h0;
  localparam logic [31:0] LOFS_MAX = 32'h0098967F;
  localparam logic [1:0] PORT_ONE = 2'h1;
  localparam logic [1:0] PORT_TWO = 2'h2;
  // Trigger types
  localparam logic [2:0] TRG_HIGH = 3'h0;
  localparam logic [2:0] TRG_LOW = 3'h1;
  localparam logic [2:0] TRG_RISE = 3'h2;
  localparam logic [2:0] TRG_FALL = 3'h3;
  localparam logic [2:0] TRG_AND = 3'h4;
  localparam logic [2:0] TRG_NAND = 3'h5;

  typedef enum logic [1:0] {
    VLS_IDLE = 2'b01,
    VLS_RUN = 2'b10
  } vls_meas_e;

  typedef struct packed {
    logic [31:0] value;
    logic valid;
  } vls_vel_s;

  typedef struct packed {
    logic [15:0] step;
    logic valid;
  } vls_len_s;
endpackage : vls_pkg
`default_nettype wire

//--- verilog/vls_supervisor.sv
// Signal-hold, rate, trigger and length supervision with an APB register file
//
// Local design decisions: the register offsets and the APB register port.
`default_nettype none
// How it works
// - Last valid velocity stays on the output through a dropout, hold 10..65535 ms.
// - Dropout longer than the hold time forces the velocity output to zero.
// - Nonzero lead raises status and red lamp at hold minus lead.
// - Positive length offset, up to 999.9999, is added to every length output.
// - Minimum rate 1..99 enables rate monitoring, zero disables it.
// - Rate below minimum opens status and turns the lamp red.
// - Rate is compared only at the end of each averaging period.
// - Surface control switched on suppresses rate monitoring.
// - Part counter loads a written 0..65535 value and reads back the count.
// - Part counter starts at zero after power-up.
// - Each recognised trigger event adds one to the part counter, unless a host load lands in the same cycle.
// - Second-trigger select makes the standby input a further trigger.
// - With error handling on, a dropout while measuring raises a critical error.
// - With error handling on, a dropout in calibration flags an error and aborts it unless that error is still flagged.
// - Single-part start clears the length and begins integrating.
// - Continuous start closes the running length and opens a new one at once.
// - Stop halts integration in single-part mode only.
// - Port query answers 1 for the first serial port and 2 for the second.
// - Single part measures over the active level; continuous restarts on each edge of the selected kind, rising or falling.
// - While a command runs, data output pauses and the busy lamp is on.
module vls_supervisor #(
  parameter int MsCycles = vls_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vls_pkg::vls_vel_s velIn,
  input wire vls_pkg::vls_len_s lenIn,
  input wire logic burstPulse,
  input wire logic avgEnd,
  input wire logic trigIn,
  input wire logic standbyIn,
  input wire logic calActive,
  input wire logic cmdActive,
  input wire logic cmdPortTwo,
  output logic [31:0] velOut,
  output logic [31:0] lengthOut,
  output logic lengthValid,
  output logic statusOpen,
  output logic redLamp,
  output logic busyLamp,
  output logic dataOutEn,
  output logic doubleGrid,
  output logic critError,
  output logic calAbort
);
  import vls_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic modeBit_r, selTrig_r, sigErrOn_r, surfaceOn_r;
  logic [2:0] trigType_r;
  logic [15:0] holdMs_r, leadMs_r, partCnt_r;
  logic [31:0] lenOfs_r;
  logic [6:0] minRate_r;
  logic [1:0] portOfEntry_r;
  logic [31:0] velHold_r, lenAcc_r, lenResult_r;
  logic [16:0] dropMs_r;
  logic [31:0] msDiv_r;
  logic [7:0] burstCnt_r;
  logic rateLow_r, crit_r, calErr_r, calAbort_r, lenValid_r;
  logic trigPrev_r;
  logic [31:0] prdata_r;
  vls_meas_e meas_r;

  logic wrEn, rdSetup, mapped, startCmd, stopCmd, clrStat;
  logic msTick, expired, warn, dropout;
  logic trigLevel, trigActive, trigRise, trigFall, trigEvent, contMode;
  logic [31:0] lenWithOfs, statWord;

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Read data is captured in the setup cycle so that it leaves a flip-flop
  assign wrEn = psel & penable & pwrite & mapped;
  assign rdSetup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;

  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_HOLD, OFS_LOFS, OFS_RATE, OFS_CNT,
      OFS_STAT, OFS_VEL, OFS_LEN, OFS_PORT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign startCmd = wrEn && paddr == OFS_CTRL && pwdata[CTRL_START];
  assign stopCmd = wrEn && paddr == OFS_CTRL && pwdata[CTRL_STOP];
  assign clrStat = wrEn && paddr == OFS_STAT;

  always_comb begin
    statWord = '0;
    statWord[ST_STATUS] = statusOpen;
    statWord[ST_WARN] = warn;
    statWord[ST_ZERO] = expired;
    statWord[ST_RATELOW] = rateLow_r;
    statWord[ST_CRIT] = crit_r;
    statWord[ST_CALERR] = calErr_r;
    statWord[ST_BUSY] = cmdActive;
    statWord[ST_MEAS] = meas_r == VLS_RUN;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (rdSetup) begin
      case (paddr)
        OFS_CTRL: prdata_r <= {25'h0, trigType_r, surfaceOn_r, sigErrOn_r, selTrig_r, modeBit_r};
        OFS_HOLD: prdata_r <= {leadMs_r, holdMs_r};
        OFS_LOFS: prdata_r <= lenOfs_r;
        OFS_RATE: prdata_r <= {25'h0, minRate_r};
        OFS_CNT: prdata_r <= {16'h0, partCnt_r};
        OFS_STAT: prdata_r <= statWord;
        OFS_VEL: prdata_r <= velOut;
        OFS_LEN: prdata_r <= lengthOut;
        OFS_PORT: prdata_r <= {30'h0, portOfEntry_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration; hold and minimum rate are clamped to the legal span, the length offset and lead are not
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modeBit_r <= 1'b0;
      selTrig_r <= 1'b0;
      sigErrOn_r <= 1'b0;
      surfaceOn_r <= 1'b0;
      trigType_r <= TRIG_RST;
      holdMs_r <= HOLD_RST;
      leadMs_r <= LEAD_RST;
      lenOfs_r <= 32'h0000_0000;
      minRate_r <= 7'h00;
    end else if (wrEn) begin
      case (paddr)
        OFS_CTRL: begin
          modeBit_r <= pwdata[CTRL_MODE];
          selTrig_r <= pwdata[CTRL_SELTRIG];
          sigErrOn_r <= pwdata[CTRL_SIGERR];
          surfaceOn_r <= pwdata[CTRL_SURF];
          trigType_r <= pwdata[CTRL_TRIG_LSB +: 3];
        end
        OFS_HOLD: begin
          holdMs_r <= (pwdata[15:0] < HOLD_MIN) ? HOLD_MIN : pwdata[15:0];
          leadMs_r <= pwdata[31:16];
        end
        OFS_LOFS: lenOfs_r <= pwdata;
        OFS_RATE: minRate_r <= (pwdata[6:0] > RATE_MAX) ? RATE_MAX : pwdata[6:0];
        default: ;
      endcase
    end
  end

  assign doubleGrid = modeBit_r;

  // ---------------------------------------------------------------
  // Dropout timing
  // ---------------------------------------------------------------
  assign msTick = msDiv_r == 32'(MsCycles - 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      msDiv_r <= 32'h0000_0000;
    end else if (velIn.valid || msTick) begin
      msDiv_r <= 32'h0000_0000;
    end else begin
      msDiv_r <= msDiv_r + 32'h0000_0001;
    end
  end

  // Saturates one above the largest hold, so a long dropout never wraps back
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dropMs_r <= 17'h00000;
    end else if (velIn.valid) begin
      dropMs_r <= 17'h00000;
    end else if (msTick && !dropMs_r[16]) begin
      dropMs_r <= dropMs_r + 17'h00001;
    end
  end

  assign dropout = dropMs_r != 17'h00000;
  assign expired = dropMs_r > {1'b0, holdMs_r};
  // Host keeps hold above lead, so the difference cannot wrap
  assign warn = leadMs_r != 16'h0000 &&
                dropMs_r >= {1'b0, holdMs_r - leadMs_r};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      velHold_r <= 32'h0000_0000;
    end else if (velIn.valid) begin
      velHold_r <= velIn.value;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      velOut <= 32'h0000_0000;
    end else begin
      velOut <= expired ? 32'h0000_0000 : velHold_r;
    end
  end

  // ---------------------------------------------------------------
  // Measuring rate
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      burstCnt_r <= 8'h00;
    end else if (avgEnd) begin
      burstCnt_r <= {7'h00, burstPulse};
    end else if (burstPulse && burstCnt_r != 8'hFF) begin
      burstCnt_r <= burstCnt_r + 8'h01;
    end
  end

  // Sampled once per averaging period; stands until the next period ends, cleared at once when minimum rate is zero or surface control is on
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rateLow_r <= 1'b0;
    end else if (minRate_r == 7'h00 || surfaceOn_r) begin
      rateLow_r <= 1'b0;
    end else if (avgEnd) begin
      rateLow_r <= burstCnt_r < {1'b0, minRate_r};
    end
  end

  assign statusOpen = warn || rateLow_r;
  assign redLamp = statusOpen;

  // ---------------------------------------------------------------
  // Trigger
  // ---------------------------------------------------------------
  assign trigLevel = trigIn | (selTrig_r & standbyIn);
  assign contMode = trigType_r == TRG_RISE || trigType_r == TRG_FALL;

  always_comb begin
    case (trigType_r)
      TRG_HIGH: trigActive = trigLevel;
      TRG_LOW: trigActive = ~trigLevel;
      TRG_AND: trigActive = trigIn & standbyIn;
      TRG_NAND: trigActive = ~(trigIn & standbyIn);
      default: trigActive = trigLevel;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trigPrev_r <= 1'b0;
    end else begin
      trigPrev_r <= trigActive;
    end
  end

  assign trigRise = trigActive & ~trigPrev_r;
  assign trigFall = ~trigActive & trigPrev_r;

  always_comb begin
    case (trigType_r)
      TRG_RISE: trigEvent = trigRise;
      TRG_FALL: trigEvent = trigFall;
      default: trigEvent = trigRise;
    endcase
  end

  // A host load in the same cycle as a trigger takes precedence
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      partCnt_r <= 16'h0000;
    end else if (wrEn && paddr == OFS_CNT) begin
      partCnt_r <= pwdata[15:0];
    end else if (trigEvent) begin
      partCnt_r <= partCnt_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Length integration
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meas_r <= VLS_IDLE;
    end else begin
      case (meas_r)
        VLS_IDLE: begin
          if (contMode || startCmd || trigEvent) begin
            meas_r <= VLS_RUN;
          end
        end
        VLS_RUN: begin
          if (!contMode && (stopCmd || trigFall)) begin
            meas_r <= VLS_IDLE;
          end
        end
        default: meas_r <= VLS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lenAcc_r <= 32'h0000_0000;
    end else if (startCmd || trigEvent) begin
      lenAcc_r <= 32'h0000_0000;
    end else if (meas_r == VLS_RUN && lenIn.valid) begin
      lenAcc_r <= lenAcc_r + {{16{lenIn.step[15]}}, lenIn.step};
    end
  end

  // Result is closed by the edge in continuous mode, by stop or level end otherwise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lenResult_r <= 32'h0000_0000;
      lenValid_r <= 1'b0;
    end else begin
      lenValid_r <= 1'b0;
      if (meas_r == VLS_RUN && contMode && (startCmd || trigEvent)) begin
        lenResult_r <= lenAcc_r;
        lenValid_r <= 1'b1;
      end else if (meas_r == VLS_RUN && !contMode && (stopCmd || trigFall)) begin
        lenResult_r <= lenAcc_r;
        lenValid_r <= 1'b1;
      end
    end
  end

  // Offset is only applied while positive; negative values are kept but unused
  assign lenWithOfs = lenResult_r + ((!lenOfs_r[31] && lenOfs_r != 32'h0) ?
                      lenOfs_r : 32'h0000_0000);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lengthOut <= 32'h0000_0000;
      lengthValid <= 1'b0;
    end else begin
      lengthOut <= lenWithOfs;
      lengthValid <= lenValid_r;
    end
  end

  // ---------------------------------------------------------------
  // Signal-loss errors
  // ---------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crit_r <= 1'b0;
      calErr_r <= 1'b0;
    end else begin
      if (sigErrOn_r && dropout && meas_r == VLS_RUN) begin
        crit_r <= 1'b1;
      end else if (clrStat && pwdata[ST_CRIT]) begin
        crit_r <= 1'b0;
      end
      if (sigErrOn_r && dropout && calActive) begin
        calErr_r <= 1'b1;
      end else if (clrStat && pwdata[ST_CALERR]) begin
        calErr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      calAbort_r <= 1'b0;
    end else begin
      calAbort_r <= sigErrOn_r && dropout && calActive && !calErr_r;
    end
  end

  assign critError = crit_r;
  assign calAbort = calAbort_r;

  // ---------------------------------------------------------------
  // Command handling
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      portOfEntry_r <= PORT_ONE;
    end else if (cmdActive) begin
      portOfEntry_r <= cmdPortTwo ? PORT_TWO : PORT_ONE;
    end
  end

  assign busyLamp = cmdActive;
  assign dataOutEn = ~cmdActive;
endmodule : vls_supervisor
`default_nettype wire
